// File: design/sync_serial_pkg.sv
// Constants for the synchronous serial port mode control block.
// Assumes a single 10 MHz core clock and a plain register port.
package sync_serial_pkg;
  localparam logic [1:0] ADDR_CONTROL      = 2'h0;
  localparam logic [1:0] ADDR_DIRECTION    = 2'h1;
  localparam logic [1:0] ADDR_SHIFT_DATA   = 2'h2;
  localparam logic [1:0] ADDR_STATUS       = 2'h3;
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] DIRECTION_RESET   = 8'hff;
  localparam int         ENABLE_POS        = 5;
  localparam int         CLOCK_HOLD_POS    = 4;
  localparam int         DATA_IN_DIR_POS   = 1;
  localparam int         DATA_OUT_DIR_POS  = 2;
  localparam int         CLOCK_DIR_POS     = 4;
  localparam int         SELECT_DIR_POS    = 5;
  localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
  localparam logic [3:0] MODE_SLAVE_FREE   = 4'h5;
  localparam logic [3:0] MODE_I2C_SLAVE7   = 4'h6;
  localparam logic [3:0] MODE_I2C_SLAVE10  = 4'h7;
  localparam logic [3:0] MODE_I2C_FW_MAST  = 4'hb;
  localparam logic [3:0] MODE_I2C_SLAVE7I  = 4'he;
  localparam logic [3:0] MODE_I2C_SLAVE10I = 4'hf;
  localparam logic [5:0] HALF_DIV4         = 6'h01;
  localparam logic [5:0] HALF_DIV16        = 6'h07;
  localparam logic [5:0] HALF_DIV64        = 6'h1f;
  localparam logic [2:0] BITS_LAST         = 3'h7;
endpackage : sync_serial_pkg

// File: design/sync_serial_shift.sv
// Eight-bit shift register with registered read data.
// Assumes shift and load strobes are never high together.
module sync_serial_shift (
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic       clear_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_data_in,
  input  wire logic       shift_in,
  input  wire logic       bit_in,
  output logic      [7:0] data_out
);
  typedef struct packed {
    logic [7:0] data;
  } shift_state_type;
  shift_state_type s_q;
  shift_state_type s_d;
  always_comb begin
    s_d = s_q;
    if (clear_in) begin
      s_d.data = 8'h00;
    end else if (load_in) begin
      s_d.data = load_data_in;
    end else if (shift_in) begin
      s_d.data = {s_q.data[6:0], bit_in};
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign data_out = s_q.data;
endmodule : sync_serial_shift

// File: design/sync_serial_port.sv
// Mode selection, clock generation and pin control of the serial port.
// Assumes synchronous pins and a one-cycle register port with no wait.
// Operation
// - Master modes 0000, 0001 and 0010 make the serial clock at core clock over 4, 16 and 64.
// - Mode 0011 is master with the serial clock at half the second timer output rate.
// - Mode 0100 is slave clocked from the clock pin with slave select gating transfers.
// - In mode 0100 a high slave select resets the serial logic.
// - In mode 0100 the data-out direction readback shows the port output enable.
// - A direction write while select is high in mode 0100 sets the data-out direction bit.
//
// Our own choices: the plain strobed port and the register offsets.
module sync_serial_port
  import sync_serial_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       write_in,
  input  wire logic       read_in,
  output logic      [7:0] rdata_out,
  input  wire logic       timer_tick_in,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_n_out,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  output logic            sdo_oe_n_out,
  input  wire logic       ss_n_in,
  output logic            i2c_mode_out
);
  //////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } xfer_state_type;
  typedef struct packed {
    logic [7:0]     control;
    logic [7:0]     direction;
    logic [7:0]     rdata;
    logic [5:0]     div;
    logic           sck;
    logic           sck_oe_n;
    logic           sdo;
    logic           sdo_oe_n;
    logic           sck_prev;
    logic [2:0]     bits;
    logic           full;
    logic           i2c;
    xfer_state_type st;
  } port_state_type;
  port_state_type s_q;
  port_state_type s_d;
  logic [7:0] shift_data;
  logic       shift_load;
  logic       shift_en;
  logic       shift_clear;
  logic [3:0] mode;
  logic       enabled;
  logic       is_master;
  logic       is_slave;
  logic       is_i2c;
  logic       select_reset;
  logic       gated;
  logic       sck_rise;
  logic       sck_fall;
  logic       master_tick;
  logic [5:0] half_limit;
  logic       out_oe_n;
  //////////////////////////////////////////////////////////////////////
  sync_serial_shift sync_serial_shift_i (
    .mclk_in      (mclk_in),
    .rstn_in      (rstn_in),
    .clear_in     (shift_clear),
    .load_in      (shift_load),
    .load_data_in (wdata_in),
    .shift_in     (shift_en),
    .bit_in       (sdi_in),
    .data_out     (shift_data)
  );
  //////////////////////////////////////////////////////////////////////
  always_comb begin
    mode      = s_q.control[3:0];
    enabled   = s_q.control[ENABLE_POS];
    is_master = enabled && (mode <= MODE_MASTER_TIMER);
    is_slave  = enabled && (mode == MODE_SLAVE_SELECT || mode == MODE_SLAVE_FREE);
    unique case (mode)
      MODE_I2C_SLAVE7, MODE_I2C_SLAVE10, MODE_I2C_FW_MAST,
      MODE_I2C_SLAVE7I, MODE_I2C_SLAVE10I: is_i2c = enabled;
      default:                              is_i2c = 1'b0;
    endcase
    select_reset = enabled && (mode == MODE_SLAVE_SELECT) && ss_n_in;
    gated        = !select_reset;
    unique case (mode)
      MODE_MASTER_DIV16: half_limit = HALF_DIV16;
      MODE_MASTER_DIV64: half_limit = HALF_DIV64;
      default:           half_limit = HALF_DIV4;
    endcase
    out_oe_n = !((is_master || is_slave) && gated);
    s_d   = s_q;
    shift_load  = 1'b0;
    shift_en    = 1'b0;
    shift_clear = 1'b0;
    master_tick = 1'b0;
    // Clock generation for master modes
    if (is_master && s_q.st != ST_IDLE) begin
      if (mode == MODE_MASTER_TIMER) begin
        master_tick = timer_tick_in;
      end else if (s_q.div == half_limit) begin
        s_d.div     = 6'h00;
        master_tick = 1'b1;
      end else begin
        s_d.div = s_q.div + 6'h01;
      end
    end else begin
      s_d.div = 6'h00;
    end
    if (master_tick) begin
      s_d.sck = !s_q.sck;
    end
    s_d.sck_prev = sck_in;
    sck_rise = is_master ? (master_tick && !s_q.sck) : (sck_in && !s_q.sck_prev);
    sck_fall = is_master ? (master_tick && s_q.sck) : (!sck_in && s_q.sck_prev);
    // Transfer sequencing
    unique case (s_q.st)
      ST_IDLE: begin
        if (is_slave && gated) begin
          s_d.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sck_rise) begin
          shift_en = 1'b1;
          s_d.bits = s_q.bits + 3'h1;
          if (s_q.bits == BITS_LAST) begin
            s_d.st   = ST_DONE;
            s_d.full = 1'b1;
          end
        end
        if (sck_fall) begin
          s_d.sdo = shift_data[7];
        end
      end
      ST_DONE: begin
        // Master ends on a falling edge so the clock idles low
        if (!is_master || master_tick) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // Register writes
    if (write_in) begin
      unique case (addr_in)
        ADDR_CONTROL: s_d.control = wdata_in;
        ADDR_DIRECTION: begin
          s_d.direction = wdata_in;
          if (select_reset) begin
            s_d.direction[DATA_OUT_DIR_POS] = 1'b1;
          end
        end
        ADDR_SHIFT_DATA: begin
          shift_load = 1'b1;
          s_d.bits   = 3'h0;
          // First bit stands before the first rising edge
          s_d.sdo    = wdata_in[7];
          s_d.st     = ST_SHIFT;
        end
        default: ;
      endcase
    end
    if (read_in && addr_in == ADDR_SHIFT_DATA && !(s_q.st == ST_SHIFT && sck_rise && s_q.bits == BITS_LAST)) begin
      s_d.full = 1'b0;
    end
    // Reset of the serial logic
    if (!enabled || select_reset) begin
      s_d.st    = ST_IDLE;
      s_d.bits  = 3'h0;
      s_d.sck   = 1'b0;
      shift_clear = !enabled;
    end
    // Pin drive
    if (is_i2c) begin
      s_d.sck      = 1'b0;
      s_d.sck_oe_n = s_q.control[CLOCK_HOLD_POS];
      s_d.sdo_oe_n = 1'b1;
    end else begin
      s_d.sck_oe_n = !(is_master && !s_q.direction[CLOCK_DIR_POS]);
      s_d.sdo_oe_n = out_oe_n || s_q.direction[DATA_OUT_DIR_POS];
    end
    s_d.i2c = is_i2c;
    // Read data
    s_d.rdata = 8'h00;
    if (read_in) begin
      unique case (addr_in)
        ADDR_CONTROL:    s_d.rdata = s_q.control;
        ADDR_DIRECTION: begin
          s_d.rdata = s_q.direction;
          if (enabled && mode == MODE_SLAVE_SELECT) begin
            s_d.rdata[DATA_OUT_DIR_POS] = out_oe_n;
          end
        end
        ADDR_SHIFT_DATA: s_d.rdata = shift_data;
        ADDR_STATUS:     s_d.rdata = {5'h00, s_q.st == ST_SHIFT, is_i2c, s_q.full};
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q           <= '0;
      s_q.control   <= CONTROL_RESET;
      s_q.direction <= DIRECTION_RESET;
      s_q.sck_oe_n  <= 1'b1;
      s_q.sdo_oe_n  <= 1'b1;
      s_q.st        <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
  assign rdata_out    = s_q.rdata;
  assign sck_out      = s_q.sck;
  assign sck_oe_n_out = s_q.sck_oe_n;
  assign sdo_out      = s_q.sdo;
  assign sdo_oe_n_out = s_q.sdo_oe_n;
  assign i2c_mode_out = s_q.i2c;
  //////////////////////////////////////////////////////////////////////
  AST_DIV4_PERIOD: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (is_master && mode == MODE_MASTER_DIV4 && s_q.st == ST_SHIFT && master_tick)
      |=> !master_tick ##1 (master_tick || s_q.st != ST_SHIFT || !is_master))
    else $error("div4 clock period wrong");
  AST_TIMER_HALF: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (is_master && mode == MODE_MASTER_TIMER && s_q.st == ST_SHIFT)
      |=> (sck_out != $past(sck_out)) == $past(timer_tick_in))
    else $error("timer clock not halved");
  AST_SELECT_RESET: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (select_reset && !write_in) |=> s_q.st == ST_IDLE && s_q.bits == 3'h0)
    else $error("select high did not reset logic");
  AST_FREE_SELECT: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (is_slave && mode == MODE_SLAVE_FREE && ss_n_in && s_q.st == ST_SHIFT && !write_in)
      |=> s_q.st != ST_IDLE)
    else $error("select honoured in free mode");
  AST_OE_READBACK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (read_in && addr_in == ADDR_DIRECTION && enabled && mode == MODE_SLAVE_SELECT)
      |=> rdata_out[DATA_OUT_DIR_POS] == $past(out_oe_n))
    else $error("direction readback not output enable");
  AST_RMW_SETS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (write_in && addr_in == ADDR_DIRECTION && select_reset) |=> s_q.direction[DATA_OUT_DIR_POS])
    else $error("data out direction not set");
  AST_HOLD_CLOCK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    is_i2c |=> !sck_out && sck_oe_n_out == $past(s_q.control[CLOCK_HOLD_POS]))
    else $error("clock hold wrong");
  AST_DISABLE_IDLE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    !enabled |=> s_q.st == ST_IDLE ##1 (s_q.st == ST_IDLE || enabled || write_in))
    else $error("disabled port not idle");
endmodule : sync_serial_port

// File: testbench/spi_peer.sv
// Far-side serial peer: a slave in master modes, a clock source in slave modes.
// Assumes pin levels resolved by the bench; shifts MSB first.
module spi_peer (
  input  wire logic       mclk_in,
  input  wire logic       load_in,
  input  wire logic       run_in,
  input  wire logic [7:0] tx_in,
  input  wire logic       sck_in,
  input  wire logic       sdo_in,
  output logic            sck_out,
  output logic            sdi_out,
  output logic      [7:0] rx_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_q;
  logic [6:0] cnt_q;
  assign sdi_out = tx_q[7];
  initial begin
    sck_out = 1'b0;
    cnt_q = 7'h40;
  end
  // Sixteen edges, four core cycles apart, clock idles low
  always @(posedge mclk_in) begin
    if (load_in) begin
      cnt_q <= 7'h00;
      sck_out <= 1'b0;
    end else if (run_in && cnt_q < 7'h40) begin
      cnt_q <= cnt_q + 7'h01;
      if (cnt_q[1:0] == 2'h3) sck_out <= ~sck_out;
    end
  end
  always @(posedge sck_in) rx_out <= {rx_out[6:0], sdo_in};
  // Each bit shifted out is refilled, inverted, at the low end
  always @(negedge sck_in or posedge load_in) begin
    if (load_in) tx_q <= tx_in;
    else tx_q <= {tx_q[6:0], ~tx_q[7]};
  end
endmodule : spi_peer

// File: testbench/sync_serial_port_mode_control_tb.sv
// Self-checking bench for the serial port mode control block.
// Assumes a 10 MHz core clock and a timer tick every five cycles.
module sync_serial_port_mode_control_tb;
  import sync_serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, rstn_in = 0, write_in = 0, read_in = 0, tick = 0, ss_n = 1, load = 0, run = 0;
  logic [1:0] addr_in = 0;
  logic [7:0] wdata_in = 0, rdata_out, rd, tx, ptx, prx;
  logic sck_out, sck_oe_n, sdo, sdo_oe_n, i2c, psck, psdi;
  int err_total = 0, comparisons = 0, seed = 27, tc = 0;
  time t0;
  wire sck_pin = sck_oe_n ? psck : sck_out;
  wire sdo_pin = sdo_oe_n ? 1'b1 : sdo;
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    tc <= (tc == 4) ? 0 : tc + 1;
    tick <= (tc == 4);
  end
  sync_serial_port sync_serial_port_i (.mclk_in, .rstn_in, .addr_in, .wdata_in, .write_in, .read_in,
    .rdata_out, .timer_tick_in(tick), .sck_in(sck_pin), .sck_out, .sck_oe_n_out(sck_oe_n), .sdi_in(psdi),
    .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .ss_n_in(ss_n), .i2c_mode_out(i2c));
  spi_peer spi_peer_i (.mclk_in, .load_in(load), .run_in(run), .tx_in(ptx), .sck_in(sck_pin),
    .sdo_in(sdo_pin), .sck_out(psck), .sdi_out(psdi), .rx_out(prx));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  function automatic logic [7:0] per(int m);
    case (m)
      0: per = 8'h04;
      1: per = 8'h10;
      2: per = 8'h40;
      default: per = 8'h0a;
    endcase
  endfunction : per
  task automatic close_out();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1;
    @(posedge mclk_in);
    write_in <= 0;
  endtask : wr
  task automatic rdr(logic [1:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    read_in <= 1;
    @(posedge mclk_in);
    read_in <= 0;
    @(negedge mclk_in);
    d = rdata_out;
  endtask : rdr
  task automatic cfg(logic [7:0] c);
    wr(ADDR_CONTROL, c & 8'hdf);
    wr(ADDR_CONTROL, c);
  endtask : cfg
  task automatic prep();
    ptx = xs();
    tx = xs();
    @(posedge mclk_in);
    load <= 1;
    @(posedge mclk_in);
    load <= 0;
  endtask : prep
  task automatic slave(logic [3:0] m, logic sel, logic ok);
    cfg({4'h2, m});
    ss_n <= ~sel;
    wr(ADDR_DIRECTION, 8'hfb);
    prep();
    wr(ADDR_SHIFT_DATA, tx);
    @(posedge mclk_in);
    run <= 1;
    repeat (72) @(posedge mclk_in);
    run <= 0;
    rdr(ADDR_STATUS, rd);
    chk({7'h0, rd[0]}, {7'h0, ok});
    if (ok) begin
      rdr(ADDR_SHIFT_DATA, rd);
      chk(rd, ptx);
      chk(prx, tx);
    end
  endtask : slave
  ////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rstn_in <= 1;
    rdr(ADDR_CONTROL, rd);
    chk(rd, CONTROL_RESET);
    rdr(ADDR_DIRECTION, rd);
    chk(rd, DIRECTION_RESET);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      cfg(8'h20 | m[7:0]);
      wr(ADDR_DIRECTION, 8'heb);
      prep();
      wr(ADDR_SHIFT_DATA, tx);
      @(posedge sck_out);
      t0 = $time;
      @(posedge sck_out);
      chk(8'(($time - t0) / 100), per(m));
      repeat (600) begin
        rdr(ADDR_STATUS, rd);
        if (rd[0]) break;
      end
      rdr(ADDR_SHIFT_DATA, rd);
      chk(rd, ptx);
      chk(prx, tx);
    end
    $display("test master done");
    slave(MODE_SLAVE_SELECT, 1, 1);
    rdr(ADDR_DIRECTION, rd);
    chk({7'h0, rd[2]}, 8'h00);
    slave(MODE_SLAVE_SELECT, 0, 0);
    rdr(ADDR_DIRECTION, rd);
    chk({7'h0, rd[2]}, 8'h01);
    wr(ADDR_DIRECTION, 8'hfb);
    ss_n <= 0;
    rdr(ADDR_DIRECTION, rd);
    chk({7'h0, rd[2]}, 8'h00);
    chk({7'h0, sdo_oe_n}, 8'h01);
    slave(MODE_SLAVE_FREE, 0, 1);
    $display("test slave done");
    wr(ADDR_DIRECTION, 8'hff);
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: tx = {4'h2, MODE_I2C_SLAVE7};
        1: tx = {4'h2, MODE_I2C_SLAVE10};
        2: tx = {4'h2, MODE_I2C_FW_MAST};
        3: tx = {4'h2, MODE_I2C_SLAVE7I};
        default: tx = {4'h2, MODE_I2C_SLAVE10I};
      endcase
      cfg(tx);
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk({5'h0, i2c, sck_oe_n, sck_out}, 8'h04);
      wr(ADDR_CONTROL, tx | 8'h10);
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk({6'h0, i2c, sck_oe_n}, 8'h03);
    end
    cfg(8'h28);
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk({6'h0, i2c, sck_oe_n}, 8'h01);
    $display("test i2c done");
    close_out();
  end
endmodule : sync_serial_port_mode_control_tb
